/* File: mailbox_read_track_sema_timeout.sv */
`timescale 1ns/1ps
`default_nettype none
module mailbox_read_track_sema_timeout (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Mailbox read events from the slave serial port logic
  input  wire logic        mbx_rd_valid,
  input  wire logic [4:0]  mbx_rd_index,
  // Semaphore state and peripheral clock gate
  input  wire logic [1:0]  sema_set,
  input  wire logic        periph_clk_run,
  // Timeout expiry flags and interrupt
  output var  logic [1:0]  timeout_expired_flag,
  output var  logic        irq
);

  // Read tracking
  logic [31:0] mbx_read_ff;
  logic [31:0] nxt_mbx_read;

  // Timeout control fields
  logic [1:0]  to_en_ff;
  logic [1:0]  nxt_to_en;
  logic [4:0]  to_exp0_ff;
  logic [4:0]  nxt_to_exp0;
  logic [4:0]  to_exp1_ff;
  logic [4:0]  nxt_to_exp1;

  // Interrupt status and enable
  logic [mbx_track_pkg::IRQ_W-1:0] irq_sts_ff;
  logic [mbx_track_pkg::IRQ_W-1:0] nxt_irq_sts;
  logic [mbx_track_pkg::IRQ_W-1:0] irq_en_ff;
  logic [mbx_track_pkg::IRQ_W-1:0] nxt_irq_en;

  // Bus answer
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pslverr_ff;
  logic        nxt_pslverr;

  // Timer outputs
  logic [1:0]  tmr_flag;
  logic [1:0]  tmr_pulse;

  // Bus phase decode
  wire         setup_ph;
  wire         wr_acc;
  wire         rd_setup;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = setup_ph & ~pwrite;

  // Address decode
  wire hit_sts0;
  wire hit_sts1;
  wire hit_sts2;
  wire hit_sts3;
  wire hit_toc0;
  wire hit_toc1;
  wire hit_rclr;
  wire hit_ists;
  wire hit_iclr;
  wire hit_ien;
  wire hit_any;

  assign hit_sts0 = (paddr == mbx_track_pkg::OFS_READ_STATUS_0);
  assign hit_sts1 = (paddr == mbx_track_pkg::OFS_READ_STATUS_1);
  assign hit_sts2 = (paddr == mbx_track_pkg::OFS_READ_STATUS_2);
  assign hit_sts3 = (paddr == mbx_track_pkg::OFS_READ_STATUS_3);
  assign hit_toc0 = (paddr == mbx_track_pkg::OFS_TIMEOUT_CTRL_0);
  assign hit_toc1 = (paddr == mbx_track_pkg::OFS_TIMEOUT_CTRL_1);
  assign hit_rclr = (paddr == mbx_track_pkg::OFS_READ_CLEAR);
  assign hit_ists = (paddr == mbx_track_pkg::OFS_IRQ_STATUS);
  assign hit_iclr = (paddr == mbx_track_pkg::OFS_IRQ_CLEAR);
  assign hit_ien  = (paddr == mbx_track_pkg::OFS_IRQ_ENABLE);
  assign hit_any  = hit_sts0 | hit_sts1 | hit_sts2 | hit_sts3 |
                    hit_toc0 | hit_toc1 | hit_rclr | hit_ists |
                    hit_iclr | hit_ien;

  // Register views
  wire [7:0] read_status_0;
  wire [7:0] read_status_1;
  wire [7:0] read_status_2;
  wire [7:0] read_status_3;
  wire [7:0] toc0_view;
  wire [7:0] toc1_view;

  assign read_status_0 =
    mbx_read_ff[mbx_track_pkg::STS0_LSB +: mbx_track_pkg::STS_W];
  assign read_status_1 =
    mbx_read_ff[mbx_track_pkg::STS1_LSB +: mbx_track_pkg::STS_W];
  assign read_status_2 =
    mbx_read_ff[mbx_track_pkg::STS2_LSB +: mbx_track_pkg::STS_W];
  assign read_status_3 =
    mbx_read_ff[mbx_track_pkg::STS3_LSB +: mbx_track_pkg::STS_W];

  // Reserved bit forced low; expiry bit is hardware-owned
  assign toc0_view = {1'b0, tmr_flag[0], to_en_ff[0], to_exp0_ff};
  assign toc1_view = {1'b0, tmr_flag[1], to_en_ff[1], to_exp1_ff};

  // Read-tracking set and clear
  wire [31:0] mbx_set;
  wire [31:0] mbx_clr;

  assign mbx_set = mbx_rd_valid ?
                   (mbx_track_pkg::MBX_ONE << mbx_rd_index) :
                   mbx_track_pkg::MBX_RESET;
  assign mbx_clr = (wr_acc && hit_rclr) ? pwdata :
                   mbx_track_pkg::MBX_RESET;

  // Set wins over a clear in the same cycle
  assign nxt_mbx_read = (mbx_read_ff & ~mbx_clr) | mbx_set;

  // Timeout control writes; bit 6 and bit 7 ignore writes
  wire [4:0] wr_exp;
  wire       wr_en_bit;

  assign wr_exp    = pwdata[mbx_track_pkg::TOC_EXP_MSB:
                            mbx_track_pkg::TOC_EXP_LSB];
  assign wr_en_bit = pwdata[mbx_track_pkg::TOC_EN_BIT];

  assign nxt_to_exp0 = (wr_acc && hit_toc0) ? wr_exp : to_exp0_ff;
  assign nxt_to_exp1 = (wr_acc && hit_toc1) ? wr_exp : to_exp1_ff;
  assign nxt_to_en[0] = (wr_acc && hit_toc0) ? wr_en_bit : to_en_ff[0];
  assign nxt_to_en[1] = (wr_acc && hit_toc1) ? wr_en_bit : to_en_ff[1];

  // Interrupt events: timer expiry only fires while enabled
  wire [mbx_track_pkg::IRQ_W-1:0] irq_evt;
  wire [mbx_track_pkg::IRQ_W-1:0] irq_clr;

  assign irq_evt[mbx_track_pkg::IRQ_TIMEOUT0_BIT] =
    tmr_pulse[0] & to_en_ff[0];
  assign irq_evt[mbx_track_pkg::IRQ_TIMEOUT1_BIT] =
    tmr_pulse[1] & to_en_ff[1];
  assign irq_evt[mbx_track_pkg::IRQ_MBX_READ_BIT] = mbx_rd_valid;

  assign irq_clr = (wr_acc && hit_iclr) ?
                   pwdata[mbx_track_pkg::IRQ_W-1:0] :
                   mbx_track_pkg::IRQ_RESET;

  assign nxt_irq_sts = (irq_sts_ff & ~irq_clr) | irq_evt;
  assign nxt_irq_en  = (wr_acc && hit_ien) ?
                       pwdata[mbx_track_pkg::IRQ_W-1:0] : irq_en_ff;

  // Read mux, captured in the setup cycle
  wire [31:0] rd_mux;

  assign rd_mux =
    hit_sts0 ? {24'h00_0000, read_status_0} :
    hit_sts1 ? {24'h00_0000, read_status_1} :
    hit_sts2 ? {24'h00_0000, read_status_2} :
    hit_sts3 ? {24'h00_0000, read_status_3} :
    hit_toc0 ? {24'h00_0000, toc0_view} :
    hit_toc1 ? {24'h00_0000, toc1_view} :
    hit_ists ? {29'h0000_0000, irq_sts_ff} :
    hit_ien  ? {29'h0000_0000, irq_en_ff} :
    mbx_track_pkg::RDATA_ZERO;

  assign nxt_prdata  = rd_setup ? rd_mux :
                       (setup_ph ? mbx_track_pkg::RDATA_ZERO : prdata_ff);
  assign nxt_pslverr = setup_ph ? ~hit_any : pslverr_ff;

  // Per-semaphore timers
  sema_timeout_timer u_timer0 (
    .pclk                 (pclk),
    .presetn              (presetn),
    .clk_run              (periph_clk_run),
    .enable               (to_en_ff[0]),
    .timeout_exponent     (to_exp0_ff),
    .sema_set             (sema_set[0]),
    .timeout_expired_flag (tmr_flag[0]),
    .expire_pulse         (tmr_pulse[0])
  );

  sema_timeout_timer u_timer1 (
    .pclk                 (pclk),
    .presetn              (presetn),
    .clk_run              (periph_clk_run),
    .enable               (to_en_ff[1]),
    .timeout_exponent     (to_exp1_ff),
    .sema_set             (sema_set[1]),
    .timeout_expired_flag (tmr_flag[1]),
    .expire_pulse         (tmr_pulse[1])
  );

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbx_read_ff <= mbx_track_pkg::MBX_RESET;
    end else begin
      mbx_read_ff <= nxt_mbx_read;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_en_ff   <= {2{mbx_track_pkg::TOC_EN_RESET}};
      to_exp0_ff <= mbx_track_pkg::TOC_EXP_RESET;
      to_exp1_ff <= mbx_track_pkg::TOC_EXP_RESET;
    end else begin
      to_en_ff   <= nxt_to_en;
      to_exp0_ff <= nxt_to_exp0;
      to_exp1_ff <= nxt_to_exp1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_ff <= mbx_track_pkg::IRQ_RESET;
      irq_en_ff  <= mbx_track_pkg::IRQ_RESET;
    end else begin
      irq_sts_ff <= nxt_irq_sts;
      irq_en_ff  <= nxt_irq_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= mbx_track_pkg::RDATA_ZERO;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Zero-wait slave: every access phase completes at once
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff & psel & penable;

  assign timeout_expired_flag = tmr_flag;
  assign irq = |(irq_sts_ff & irq_en_ff);

endmodule : mailbox_read_track_sema_timeout
`default_nettype wire

/* File: mbx_track_pkg.sv */
package mbx_track_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_READ_STATUS_0   = 12'h000;
  localparam logic [11:0] OFS_READ_STATUS_1   = 12'h004;
  localparam logic [11:0] OFS_READ_STATUS_2   = 12'h008;
  localparam logic [11:0] OFS_READ_STATUS_3   = 12'h00c;
  localparam logic [11:0] OFS_TIMEOUT_CTRL_0  = 12'h010;
  localparam logic [11:0] OFS_TIMEOUT_CTRL_1  = 12'h014;
  localparam logic [11:0] OFS_READ_CLEAR      = 12'h018;
  localparam logic [11:0] OFS_IRQ_STATUS      = 12'h01c;
  localparam logic [11:0] OFS_IRQ_CLEAR       = 12'h020;
  localparam logic [11:0] OFS_IRQ_ENABLE      = 12'h024;

  // Mailbox count and per-register slices
  localparam int          MBX_COUNT           = 32;
  localparam int          MBX_IDX_W           = 5;
  localparam int          STS_W               = 8;
  localparam int          STS0_LSB            = 24;
  localparam int          STS1_LSB            = 16;
  localparam int          STS2_LSB            = 8;
  localparam int          STS3_LSB            = 0;

  // Timeout control register layout
  localparam int          TOC_RSVD_BIT        = 7;
  localparam int          TOC_EXPIRED_BIT     = 6;
  localparam int          TOC_EN_BIT          = 5;
  localparam int          TOC_EXP_MSB         = 4;
  localparam int          TOC_EXP_LSB         = 0;
  localparam int          TOC_EXP_W           = 5;
  localparam logic [4:0]  TOC_EXP_RESET       = 5'h00;
  localparam logic        TOC_EN_RESET        = 1'b0;

  // Timer length is base times two to the exponent
  localparam int          TMR_BASE_LOG2       = 7;
  localparam int          TMR_W               = TMR_BASE_LOG2 + 32;
  localparam logic [TMR_W-1:0] TMR_BASE       = 39'h00_0000_0080;
  localparam logic [TMR_W-1:0] TMR_LAST       = 39'h00_0000_0001;

  // Interrupt status layout
  localparam int          IRQ_W               = 3;
  localparam int          IRQ_TIMEOUT0_BIT    = 0;
  localparam int          IRQ_TIMEOUT1_BIT    = 1;
  localparam int          IRQ_MBX_READ_BIT    = 2;
  localparam logic [2:0]  IRQ_RESET           = 3'h0;

  localparam logic [31:0] MBX_RESET           = 32'h0000_0000;
  localparam logic [31:0] MBX_ONE             = 32'h0000_0001;
  localparam logic [31:0] RDATA_ZERO          = 32'h0000_0000;

endpackage : mbx_track_pkg

/* File: sema_timeout_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sema_timeout_timer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_run,
  input  wire logic       enable,
  input  wire logic [4:0] timeout_exponent,
  input  wire logic       sema_set,
  output var  logic       timeout_expired_flag,
  output var  logic       expire_pulse
);

  logic [mbx_track_pkg::TMR_W-1:0] cnt_ff;
  logic [mbx_track_pkg::TMR_W-1:0] nxt_cnt;
  logic                            active_ff;
  logic                            nxt_active;
  logic                            flag_ff;
  logic                            nxt_flag;
  logic                            pulse_ff;
  logic                            nxt_pulse;
  logic                            sema_q_ff;

  wire                             sema_rise;
  wire  [mbx_track_pkg::TMR_W-1:0] load_len;

  assign sema_rise = sema_set & ~sema_q_ff;
  assign load_len  = mbx_track_pkg::TMR_BASE << timeout_exponent;

  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_active = active_ff;
    nxt_flag   = flag_ff;
    nxt_pulse  = 1'b0;
    if (!sema_set) begin
      nxt_active = 1'b0;
      nxt_flag   = 1'b0;
    end else if (sema_rise && clk_run && enable) begin
      // A rise seen while stopped is lost for good
      nxt_cnt    = load_len;
      nxt_active = 1'b1;
    end else if (!enable) begin
      nxt_active = 1'b0;
    end else if (active_ff && clk_run) begin
      if (cnt_ff == mbx_track_pkg::TMR_LAST) begin
        nxt_cnt    = '0;
        nxt_active = 1'b0;
        nxt_flag   = 1'b1;
        nxt_pulse  = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - mbx_track_pkg::TMR_LAST;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff    <= '0;
      active_ff <= 1'b0;
      flag_ff   <= 1'b0;
      pulse_ff  <= 1'b0;
      sema_q_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      active_ff <= nxt_active;
      flag_ff   <= nxt_flag;
      pulse_ff  <= nxt_pulse;
      sema_q_ff <= sema_set;
    end
  end

  assign timeout_expired_flag = flag_ff;
  assign expire_pulse         = pulse_ff;

endmodule : sema_timeout_timer
`default_nettype wire

/* File: mbx_track_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module mbx_track_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mbx_rd_valid,
  input wire logic [4:0]  mbx_rd_index,
  input wire logic [1:0]  sema_set,
  input wire logic        periph_clk_run,
  input wire logic [1:0]  timeout_expired_flag,
  input wire logic        irq
);
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic ctl0   = paddr == mbx_track_pkg::OFS_TIMEOUT_CTRL_0;
  wire logic ctl1   = paddr == mbx_track_pkg::OFS_TIMEOUT_CTRL_1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  rsvd_zero_a: assert property (
    rd_acc && (ctl0 || ctl1) |-> !prdata[7])
    else $error("reserved timeout bit reads one");
  flag_mirror_a: assert property (
    rd_acc && ctl0 |-> prdata[6] == $past(timeout_expired_flag[0]))
    else $error("expiry bit differs from flag");
  flag_clear_a: assert property (
    !sema_set[0] |=> !timeout_expired_flag[0])
    else $error("flag kept after semaphore clear");
  flag_hold_a: assert property (
    timeout_expired_flag[1] && sema_set[1] |=> timeout_expired_flag[1])
    else $error("flag dropped while semaphore set");
  needs_sema_a: assert property (
    $rose(timeout_expired_flag[1]) |-> $past(sema_set[1]))
    else $error("expiry without semaphore");
  needs_run_a: assert property (
    $rose(timeout_expired_flag[0]) |-> $past(periph_clk_run))
    else $error("expiry while clock stopped");
  min_len_a: assert property (
    $rose(sema_set[0]) |=> !timeout_expired_flag[0] [*8])
    else $error("expiry too early");
  // Expiry reaches the status bit one edge after the flag rises
  irq_cause_a: assert property (
    $rose(irq) |-> $past(mbx_rd_valid) || $past(wr_acc)
      || |($past(timeout_expired_flag) & ~$past(timeout_expired_flag, 2)))
    else $error("interrupt without cause");
  cover property ($rose(timeout_expired_flag[0]));
  cover property ($rose(irq));
  cover property (pslverr);
endmodule : mbx_track_checker
bind mailbox_read_track_sema_timeout mbx_track_checker i_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mbx_rd_valid(mbx_rd_valid),
  .mbx_rd_index(mbx_rd_index), .sema_set(sema_set),
  .periph_clk_run(periph_clk_run),
  .timeout_expired_flag(timeout_expired_flag), .irq(irq)
);
`default_nettype wire

/* File: host_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input  wire logic       pclk,
  input  wire logic       rd_go,
  input  wire logic [4:0] rd_idx,
  output var  logic       mbx_rd_valid,
  output var  logic [4:0] mbx_rd_index
);
  initial mbx_rd_valid = 1'b0;
  initial mbx_rd_index = 5'h00;
  // One-cycle read event; index toggles while idle
  always @(posedge pclk) begin
    mbx_rd_valid <= rd_go;
    mbx_rd_index <= rd_go ? rd_idx : ~mbx_rd_index;
  end
endmodule : host_port_model
`default_nettype wire

/* File: test_mailbox_read_track_sema_timeout.sv */
`timescale 1ns/1ps
`default_nettype none
module test_mailbox_read_track_sema_timeout;
  typedef struct {logic [4:0] i; logic [11:0] a; logic [31:0] x;} row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e, irq, rd_go, periph_clk_run, mbx_rd_valid;
  logic [4:0]  rd_idx, mbx_rd_index;
  logic [1:0]  sema_set, timeout_expired_flag;
  int          bad_count, cmp_count, n;
  row_t        rows [8];
  mailbox_read_track_sema_timeout i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mbx_rd_valid(mbx_rd_valid), .mbx_rd_index(mbx_rd_index),
    .sema_set(sema_set), .periph_clk_run(periph_clk_run),
    .timeout_expired_flag(timeout_expired_flag), .irq(irq));
  host_port_model i_host (.pclk(pclk), .rd_go(rd_go), .rd_idx(rd_idx),
    .mbx_rd_valid(mbx_rd_valid), .mbx_rd_index(mbx_rd_index));
  always #5 pclk = ~pclk;
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] got, x);
    cmp_count++;
    if (got !== x) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", nm, x, got);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] x);
    apb(a, 1'b0, 32'h0000_0000);
    chk(nm, q, x);
  endtask : rdchk
  task automatic host_rd(input logic [4:0] i);
    @(posedge pclk);
    rd_go <= 1'b1;
    rd_idx <= i;
    @(posedge pclk);
    rd_go <= 1'b0;
  endtask : host_rd
  task automatic wait_flag(input int s, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (timeout_expired_flag[s] !== 1'b1 && n < lim);
  endtask : wait_flag
  task automatic sema(input int s, input logic v);
    @(posedge pclk);
    sema_set[s] <= v;
  endtask : sema
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, rd_go} = 6'h00;
    {paddr, pwdata, rd_idx, sema_set} = 51'h0;
    periph_clk_run = 1'b1;
    rows = '{'{5'h10, mbx_track_pkg::OFS_READ_STATUS_1, 32'h01},
      '{5'h17, mbx_track_pkg::OFS_READ_STATUS_1, 32'h81},
      '{5'h08, mbx_track_pkg::OFS_READ_STATUS_2, 32'h01},
      '{5'h0f, mbx_track_pkg::OFS_READ_STATUS_2, 32'h81},
      '{5'h00, mbx_track_pkg::OFS_READ_STATUS_3, 32'h01},
      '{5'h07, mbx_track_pkg::OFS_READ_STATUS_3, 32'h81},
      '{5'h1f, mbx_track_pkg::OFS_READ_STATUS_0, 32'h80},
      '{5'h18, mbx_track_pkg::OFS_READ_STATUS_0, 32'h81}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++)
      rdchk("reset", 12'(4 * k), 32'h0);
    foreach (rows[k]) begin
      host_rd(rows[k].i);
      rdchk("status", rows[k].a, rows[k].x);
    end
    rdchk("sticky", mbx_track_pkg::OFS_READ_STATUS_1, 32'h81);
    apb(mbx_track_pkg::OFS_READ_CLEAR, 1'b1, 32'h0080_0000);
    rdchk("clear", mbx_track_pkg::OFS_READ_STATUS_1, 32'h01);
    rdchk("irq_sts", mbx_track_pkg::OFS_IRQ_STATUS, 32'h4);
    apb(mbx_track_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h7);
    #1 chk("irq_on", 32'(irq), 32'h1);
    apb(mbx_track_pkg::OFS_IRQ_CLEAR, 1'b1, 32'h4);
    #1 chk("irq_off", 32'(irq), 32'h0);
    apb(12'h028, 1'b0, 32'h0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    apb(mbx_track_pkg::OFS_TIMEOUT_CTRL_0, 1'b1, 32'hff);
    rdchk("rsvd", mbx_track_pkg::OFS_TIMEOUT_CTRL_0, 32'h3f);
    // Short exponents only, long waits stay in software
    apb(mbx_track_pkg::OFS_TIMEOUT_CTRL_0, 1'b1, 32'h20);
    apb(mbx_track_pkg::OFS_TIMEOUT_CTRL_1, 1'b1, 32'h22);
    sema(0, 1'b1);
    wait_flag(0, 700);
    chk("len0", n, 129);
    // Status bit, and so the interrupt, follows the flag by one edge
    @(posedge pclk);
    #1 chk("irq_to", 32'(irq), 32'h1);
    rdchk("flag0", mbx_track_pkg::OFS_TIMEOUT_CTRL_0, 32'h60);
    sema(0, 1'b0);
    @(posedge pclk);
    #1 chk("flag_clr", 32'(timeout_expired_flag), 32'h0);
    sema(1, 1'b1);
    wait_flag(1, 700);
    chk("len1", n, 513);
    sema(1, 1'b0);
    sema(0, 1'b1);
    repeat (50) @(posedge pclk);
    sema_set[0] <= 1'b0;
    wait_flag(0, 300);
    chk("stop", n, 300);
    @(posedge pclk);
    periph_clk_run <= 1'b0;
    sema(0, 1'b1);
    repeat (3) @(posedge pclk);
    periph_clk_run <= 1'b1;
    wait_flag(0, 300);
    chk("no_start", n, 300);
    sema(0, 1'b0);
    sema(0, 1'b1);
    repeat (19) @(posedge pclk);
    periph_clk_run <= 1'b0;
    repeat (200) @(posedge pclk);
    periph_clk_run <= 1'b1;
    wait_flag(0, 300);
    chk("frozen", n, 110);
    sema(0, 1'b0);
    apb(mbx_track_pkg::OFS_TIMEOUT_CTRL_0, 1'b1, 32'h00);
    sema(0, 1'b1);
    wait_flag(0, 300);
    chk("disabled", n, 300);
    // Reset in mid-run clears tracking bits, controls and interrupt
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1 chk("rst_irq", 32'(irq), 32'h0);
    rdchk("rst_sts3", mbx_track_pkg::OFS_READ_STATUS_3, 32'h0);
    rdchk("rst_toc1", mbx_track_pkg::OFS_TIMEOUT_CTRL_1, 32'h0);
    give_verdict();
  end
endmodule : test_mailbox_read_track_sema_timeout
`default_nettype wire
